// *** common/spm_pkg.sv ***
// Constants shared by the shared-pin mux and its helpers.
// Assumes one 25 MHz source clock (bus at half that rate) and a synchronous active-low reset.
package spm_pkg;
  localparam int CLK_MHZ = 25;
  localparam int DEBUG_BIT_CYCLES = 16;
  localparam int SPEEDUP_NS = 80;
  localparam int SPEEDUP_CYCLES = (SPEEDUP_NS * CLK_MHZ) / 1000;
  localparam logic RESET_PIN_ENABLE_RST = 1'b0;
  localparam logic DEBUG_PIN_ENABLE_RST = 1'b1;
  localparam logic [5:0] PULL_ENABLE_RST = 6'h00;
  localparam logic [5:0] PULL_UP_SELECT_RST = 6'h00;
  typedef enum logic [2:0]
  {
    SPM_WIRE_IDLE = 3'b001,
    SPM_WIRE_LOW = 3'b010,
    SPM_WIRE_SPEEDUP = 3'b100
  } spm_wire_e;
endpackage

// *** rtl/spm_bit_timer.sv ***
// Counts debug bit times and one-cycle bus clock enables.
// Assumes the fast clock is the internal clock source output.
module spm_bit_timer #(
  parameter int BIT_CYCLES = spm_pkg::DEBUG_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enables
  output logic bus_enable,
  output logic bit_tick
);
  logic half_q;
  logic [7:0] count_q;

  // Bus rate is half the source rate
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      half_q <= 1'b0;
    else
      half_q <= ~half_q;
  end

  // Debug controller runs at bus rate; bit is 16 of those
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_q <= 8'h00;
    else if (half_q)
    begin
      if (count_q == 8'(BIT_CYCLES - 1))
        count_q <= 8'h00;
      else
        count_q <= count_q + 8'h01;
    end
  end

  assign bus_enable = half_q;
  assign bit_tick = half_q && (count_q == 8'(BIT_CYCLES - 1));
endmodule

// *** rtl/spm_wire_driver.sv ***
// Pseudo open-drain driver for the single-wire debug pin.
// Assumes the debug controller asks for a low and a release.
module spm_wire_driver (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic drive_low,
  // Pin
  output logic wire_out,
  output logic wire_oe
);
  spm_pkg::spm_wire_e state_q;
  logic [3:0] count_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= spm_pkg::SPM_WIRE_IDLE;
      count_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        spm_pkg::SPM_WIRE_IDLE:
          if (drive_low)
            state_q <= spm_pkg::SPM_WIRE_LOW;
        spm_pkg::SPM_WIRE_LOW:
          if (!drive_low)
          begin
            // Short active high beats slow pullup rise
            state_q <= spm_pkg::SPM_WIRE_SPEEDUP;
            count_q <= 4'(spm_pkg::SPEEDUP_CYCLES - 1);
          end
        spm_pkg::SPM_WIRE_SPEEDUP:
          if (count_q == 4'h0)
            state_q <= spm_pkg::SPM_WIRE_IDLE;
          else
            count_q <= count_q - 4'h1;
        default:
          state_q <= spm_pkg::SPM_WIRE_IDLE;
      endcase
    end
  end

  assign wire_out = (state_q == spm_pkg::SPM_WIRE_SPEEDUP);
  assign wire_oe = (state_q != spm_pkg::SPM_WIRE_IDLE);

  sequence s_speedup_drive;
    wire_oe && wire_out;
  endsequence

  property p_speedup_after_low;
    @(posedge clk) disable iff (!rst_n)
    state_q == spm_pkg::SPM_WIRE_LOW && !drive_low |=> s_speedup_drive;
  endproperty
  a_speedup_after_low: assert property (p_speedup_after_low)
    else $error("no speedup after low");
endmodule

// *** rtl/spm_pin_mux.sv ***
// Pin function selection for six shared signal pins.
// Assumes synchronous pin inputs and a power-on reset on rst_n.
module spm_pin_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control from system option and port registers
  input wire logic sys_opt_write,
  input wire logic reset_pin_enable_wr,
  input wire logic debug_pin_enable_wr,
  input wire logic pull_write,
  input wire logic [5:0] pull_enable_wr,
  input wire logic [5:0] pull_up_select_wr,
  input wire logic [5:0] port_dir,
  input wire logic [5:0] port_data_out,
  // Peripheral enables
  input wire logic comp_pos_enable,
  input wire logic comp_neg_enable,
  input wire logic comp_out_enable,
  input wire logic comparator_output,
  input wire logic timer_clock_select,
  input wire logic [5:0] key_wake_enable,
  input wire logic low_power_mode,
  input wire logic programming_voltage,
  // Debug controller side
  input wire logic debug_drive_low,
  // Pins, in order bit zero to five
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] pin_pullup,
  output logic [5:0] pin_pulldown,
  output logic [5:0] pin_analog,
  // Status
  output logic reset_pin_enable,
  output logic debug_pin_enable,
  output logic boot_background,
  output logic external_reset_n,
  output logic [5:0] port_data_in,
  output logic timer_external_clock_in,
  output logic key_wake,
  output logic debug_wire_in,
  output logic bus_enable,
  output logic bit_tick
);
  logic rst_pin_q;
  logic debug_en_q;
  logic boot_bg_q;
  logic in_reset_q;
  logic [5:0] pull_en_q;
  logic [5:0] pull_up_q;
  logic wire_out;
  logic wire_oe;
  logic [5:0] key_hit;

  spm_bit_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .bus_enable(bus_enable),
    .bit_tick(bit_tick)
  );

  spm_wire_driver u_wire (
    .clk(clk),
    .rst_n(rst_n),
    .drive_low(debug_drive_low && debug_en_q && !in_reset_q),
    .wire_out(wire_out),
    .wire_oe(wire_oe)
  );

  // Only reset may clear it, so a runaway write cannot undo it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rst_pin_q <= spm_pkg::RESET_PIN_ENABLE_RST;
    else if (sys_opt_write && reset_pin_enable_wr)
      rst_pin_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      debug_en_q <= spm_pkg::DEBUG_PIN_ENABLE_RST;
    else if (sys_opt_write)
      debug_en_q <= debug_pin_enable_wr;
  end

  // Mode pin sampled once, on the first clock after rst_n rises, then held
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      in_reset_q <= 1'b1;
    else
      in_reset_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      boot_bg_q <= 1'b0;
    else if (in_reset_q)
      boot_bg_q <= !pin_in[3];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pull_en_q <= spm_pkg::PULL_ENABLE_RST;
      pull_up_q <= spm_pkg::PULL_UP_SELECT_RST;
    end
    else if (pull_write)
    begin
      pull_en_q <= pull_enable_wr;
      pull_up_q <= pull_up_select_wr;
    end
  end

  // Pin ownership, highest priority first
  always_comb
  begin
    pin_out = 6'h00;
    pin_oe = 6'h00;
    pin_analog = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      pin_pullup[i] = pull_en_q[i] && pull_up_q[i];
      pin_pulldown[i] = pull_en_q[i] && !pull_up_q[i];
    end
    // Bits zero and one: analog input beats port
    pin_analog[0] = comp_pos_enable;
    pin_analog[1] = comp_neg_enable;
    for (int i = 0; i < 6; i++)
    begin
      if (i != 2 && i != 3 && !pin_analog[i])
      begin
        pin_out[i] = port_data_out[i];
        pin_oe[i] = port_dir[i];
      end
    end
    // Bit two is input only
    if (programming_voltage)
    begin
      pin_pullup[2] = 1'b0;
      pin_pulldown[2] = 1'b0;
    end
    else if (rst_pin_q)
    begin
      pin_pullup[2] = 1'b1;
      pin_pulldown[2] = 1'b0;
    end
    // Bit three: mode select or debug, then comparator, then port
    if (in_reset_q || debug_en_q)
    begin
      pin_pullup[3] = 1'b1;
      pin_pulldown[3] = 1'b0;
      pin_out[3] = wire_out;
      pin_oe[3] = wire_oe;
    end
    else if (comp_out_enable)
    begin
      pin_out[3] = comparator_output;
      pin_oe[3] = 1'b1;
    end
    else
    begin
      pin_out[3] = port_data_out[3];
      pin_oe[3] = 1'b1;
    end
  end

  // External reset only while the pin owns that function
  assign external_reset_n = !(rst_pin_q && !pin_in[2]);
  assign timer_external_clock_in = timer_clock_select && !rst_pin_q
    && pin_in[2];

  always_comb
  begin
    port_data_in = pin_in & ~pin_analog;
    port_data_in[2] = pin_in[2] && !rst_pin_q;
    port_data_in[3] = 1'b0;
  end

  // Key wake only counts in stop or wait
  always_comb
  begin
    key_hit = key_wake_enable & ~pin_in & ~pin_analog;
    key_hit[2] = key_hit[2] && !rst_pin_q;
    key_hit[3] = 1'b0;
  end
  assign key_wake = low_power_mode && (key_hit != 6'h00);

  assign debug_wire_in = pin_in[3] && debug_en_q && !in_reset_q;
  assign reset_pin_enable = rst_pin_q;
  assign debug_pin_enable = debug_en_q;
  assign boot_background = boot_bg_q;

  // Last reset cycle, then the first running cycle
  sequence s_reset_release;
    in_reset_q ##1 !in_reset_q;
  endsequence

  sequence s_tick_gap;
    (!bit_tick)[*8];
  endsequence

  property p_reset_sticky;
    @(posedge clk) disable iff (!rst_n)
    rst_pin_q |=> rst_pin_q;
  endproperty
  a_reset_sticky: assert property (p_reset_sticky)
    else $error("reset pin function lost");

  property p_ext_reset;
    @(posedge clk) disable iff (!rst_n)
    rst_pin_q && !pin_in[2] |-> !external_reset_n;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("low reset pin ignored");

  property p_ext_reset_idle;
    @(posedge clk) disable iff (!rst_n)
    !rst_pin_q |-> external_reset_n;
  endproperty
  a_ext_reset_idle: assert property (p_ext_reset_idle)
    else $error("port pin acts as reset");

  property p_pullup_reset;
    @(posedge clk) disable iff (!rst_n)
    rst_pin_q && !programming_voltage |-> pin_pullup[2];
  endproperty
  a_pullup_reset: assert property (p_pullup_reset)
    else $error("reset pin pullup off");

  property p_vpp_pulls;
    @(posedge clk) disable iff (!rst_n)
    programming_voltage |-> !pin_pullup[2] && !pin_pulldown[2];
  endproperty
  a_vpp_pulls: assert property (p_vpp_pulls)
    else $error("pulls on under programming voltage");

  property p_debug_pullup;
    @(posedge clk) disable iff (!rst_n)
    in_reset_q || debug_en_q |-> pin_pullup[3];
  endproperty
  a_debug_pullup: assert property (p_debug_pullup)
    else $error("debug pullup off");

  property p_port_out_only;
    @(posedge clk) disable iff (!rst_n)
    !debug_en_q && !in_reset_q |-> pin_oe[3] && !port_data_in[3];
  endproperty
  a_port_out_only: assert property (p_port_out_only)
    else $error("debug port not output only");

  property p_key_wake;
    @(posedge clk) disable iff (!rst_n)
    !low_power_mode |-> !key_wake;
  endproperty
  a_key_wake: assert property (p_key_wake)
    else $error("key wake in run");

  property p_key_wake_hit;
    @(posedge clk) disable iff (!rst_n)
    low_power_mode && key_wake_enable[4] && !pin_in[4] |-> key_wake;
  endproperty
  a_key_wake_hit: assert property (p_key_wake_hit)
    else $error("key wake missed in low power");

  property p_boot_mode;
    @(posedge clk) disable iff (!rst_n)
    s_reset_release |-> boot_bg_q == !$past(pin_in[3]);
  endproperty
  a_boot_mode: assert property (p_boot_mode)
    else $error("boot mode wrong");

  property p_boot_hold;
    @(posedge clk) disable iff (!rst_n)
    !in_reset_q |=> $stable(boot_bg_q);
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("boot mode changed while running");

  property p_analog_wins;
    @(posedge clk) disable iff (!rst_n)
    comp_pos_enable |-> !pin_oe[0];
  endproperty
  a_analog_wins: assert property (p_analog_wins)
    else $error("port drives analog pin");

  property p_comp_out;
    @(posedge clk) disable iff (!rst_n)
    !in_reset_q && !debug_en_q && comp_out_enable
      |-> pin_oe[3] && pin_out[3] == comparator_output;
  endproperty
  a_comp_out: assert property (p_comp_out)
    else $error("comparator output lost the pin");

  property p_mode_pin_quiet;
    @(posedge clk) disable iff (!rst_n)
    in_reset_q |-> !pin_oe[3];
  endproperty
  a_mode_pin_quiet: assert property (p_mode_pin_quiet)
    else $error("mode pin driven in reset");

  property p_pulls_exclusive;
    @(posedge clk) disable iff (!rst_n)
    (pin_pullup & pin_pulldown) == 6'h00;
  endproperty
  a_pulls_exclusive: assert property (p_pulls_exclusive)
    else $error("pullup and pulldown both on");

  property p_timer_clock;
    @(posedge clk) disable iff (!rst_n)
    timer_clock_select && !rst_pin_q |-> timer_external_clock_in == pin_in[2];
  endproperty
  a_timer_clock: assert property (p_timer_clock)
    else $error("timer clock not from pin");

  property p_bus_alternates;
    @(posedge clk) disable iff (!rst_n)
    bus_enable |=> !bus_enable;
  endproperty
  a_bus_alternates: assert property (p_bus_alternates)
    else $error("bus enable held two cycles");

  property p_bus_resumes;
    @(posedge clk) disable iff (!rst_n)
    !bus_enable |=> bus_enable;
  endproperty
  a_bus_resumes: assert property (p_bus_resumes)
    else $error("bus enable skipped");

  property p_tick_gap;
    @(posedge clk) disable iff (!rst_n)
    bit_tick |=> s_tick_gap;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("bit ticks too close");
endmodule

// *** tb/spm_board_model.sv ***
// Board circuitry and debug pod on the six shared pins.
// Assumes the mux drives pins when its output enable is high.
module spm_board_model (
  // Clock
  clk,
  // Mux side
  pin_out,
  pin_oe,
  pin_pullup,
  pin_pulldown,
  // Board and pod drivers
  ext_en,
  ext_level,
  // Resolved pin levels
  pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  input wire logic clk;
  input wire logic [5:0] pin_out;
  input wire logic [5:0] pin_oe;
  input wire logic [5:0] pin_pullup;
  input wire logic [5:0] pin_pulldown;
  input wire logic [5:0] ext_en;
  input wire logic [5:0] ext_level;
  output logic [5:0] pin_in;
  logic [5:0] float_q = 6'h00;
  // Floating pins wander, so a stale level is never trusted
  always @(posedge clk)
    float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 6; i++)
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_level[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else if (pin_pulldown[i])
        pin_in[i] = 1'b0;
      else
        pin_in[i] = float_q[i];
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the shared pin mux.
// Assumes a board model resolves every pin level.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed
  {
    logic [5:0] en, up, lvl, pu, pd;
  } spm_row_s;
  spm_row_s rows [4] = '{
    '{6'h3F, 6'h3F, 6'h2A, 6'h3F, 6'h00},
    '{6'h3F, 6'h00, 6'h15, 6'h08, 6'h37},
    '{6'h15, 6'h05, 6'h3F, 6'h0D, 6'h10},
    '{6'h00, 6'h00, 6'h00, 6'h08, 6'h00}};
  logic clk = 1'b0, rst_n = 1'b0, sys_opt_write = 1'b0, pull_write = 1'b0;
  logic reset_pin_enable_wr = 1'b0, debug_pin_enable_wr = 1'b1;
  logic comp_pos_enable = 1'b0, comp_neg_enable = 1'b0;
  logic comp_out_enable = 1'b0, comparator_output = 1'b0;
  logic timer_clock_select = 1'b0, low_power_mode = 1'b0;
  logic programming_voltage = 1'b0, debug_drive_low = 1'b0;
  logic [5:0] pull_enable_wr = 6'h00, pull_up_select_wr = 6'h00;
  logic [5:0] port_dir = 6'h00, port_data_out = 6'h00;
  logic [5:0] key_wake_enable = 6'h00, ext_en = 6'h00, ext_level = 6'h00;
  logic [5:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown;
  logic [5:0] pin_analog, port_data_in;
  logic reset_pin_enable, debug_pin_enable, boot_background;
  logic external_reset_n, timer_external_clock_in, key_wake;
  logic debug_wire_in, bus_enable, bit_tick;
  int num_errors = 0, total_checks = 0, n_bus, n_tick;

  always #20 clk = ~clk;

  spm_pin_mux dut (.clk, .rst_n, .sys_opt_write, .reset_pin_enable_wr,
    .debug_pin_enable_wr, .pull_write, .pull_enable_wr, .pull_up_select_wr,
    .port_dir, .port_data_out, .comp_pos_enable, .comp_neg_enable,
    .comp_out_enable, .comparator_output, .timer_clock_select,
    .key_wake_enable, .low_power_mode, .programming_voltage,
    .debug_drive_low, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .pin_pulldown, .pin_analog, .reset_pin_enable, .debug_pin_enable,
    .boot_background, .external_reset_n, .port_data_in,
    .timer_external_clock_in, .key_wake, .debug_wire_in, .bus_enable,
    .bit_tick);

  spm_board_model board (.clk, .pin_out, .pin_oe, .pin_pullup,
    .pin_pulldown, .ext_en, .ext_level, .pin_in);

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t pins got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Pod holds the mode pin low through reset when asked
  task automatic por(input logic pod_low);
    ext_en[3] = pod_low;
    ext_level[3] = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    ext_en[3] = 1'b0;
  endtask

  task automatic opt_write(input logic rpe, input logic dpe);
    reset_pin_enable_wr = rpe;
    debug_pin_enable_wr = dpe;
    sys_opt_write = 1'b1;
    @(negedge clk);
    sys_opt_write = 1'b0;
    #1;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    results;
  end

  initial
  begin
    por(1'b1);
    chk1(boot_background, 1'b1);
    chk1(reset_pin_enable, 1'b0);
    chk1(external_reset_n, 1'b1);
    chk6(pin_oe, 6'h00);
    chk6(pin_pullup, 6'h08);
    chk6(pin_pulldown | pin_analog, 6'h00);
    $display("reset test done");
    ext_en = 6'h37;
    foreach (rows[i])
    begin
      pull_enable_wr = rows[i].en;
      pull_up_select_wr = rows[i].up;
      ext_level = rows[i].lvl;
      pull_write = 1'b1;
      @(negedge clk);
      pull_write = 1'b0;
      #1;
      chk6(pin_pullup, rows[i].pu);
      chk6(pin_pulldown, rows[i].pd);
      chk6(port_data_in & 6'h37, rows[i].lvl & 6'h37);
    end
    timer_clock_select = 1'b1;
    key_wake_enable = 6'h3F;
    for (int v = 0; v < 2; v++)
    begin
      ext_level = {6{v[0]}};
      #1;
      chk1(timer_external_clock_in, v[0]);
      chk1(key_wake, 1'b0);
    end
    low_power_mode = 1'b1;
    #1;
    chk1(key_wake, 1'b0);
    ext_level = 6'h2F;
    #1;
    chk1(key_wake, 1'b1);
    low_power_mode = 1'b0;
    $display("row test done");
    comp_pos_enable = 1'b1;
    comp_neg_enable = 1'b1;
    port_dir = 6'h3F;
    port_data_out = 6'h3F;
    #1;
    chk6(pin_analog & 6'h03, 6'h03);
    chk6(pin_oe, 6'h30);
    comp_pos_enable = 1'b0;
    comp_neg_enable = 1'b0;
    #1;
    chk6(pin_oe & 6'h07, 6'h03);
    @(negedge clk);
    debug_drive_low = 1'b1;
    @(negedge clk);
    chk1(pin_oe[3], 1'b1);
    chk1(pin_out[3], 1'b0);
    repeat (4) @(negedge clk);
    debug_drive_low = 1'b0;
    repeat (2)
    begin
      @(negedge clk);
      chk1(pin_oe[3] & pin_out[3], 1'b1);
    end
    @(negedge clk);
    chk1(pin_oe[3], 1'b0);
    chk1(debug_wire_in, 1'b1);
    $display("debug wire test done");
    @(negedge clk);
    n_bus = 0;
    n_tick = 0;
    repeat (64)
    begin
      @(posedge clk);
      #1;
      n_bus += int'(bus_enable === 1'b1);
      n_tick += int'(bit_tick === 1'b1);
    end
    chk6(6'(n_bus), 6'h20);
    chk6(6'(n_tick), 6'h02);
    @(negedge clk);
    opt_write(1'b0, 1'b0);
    chk1(debug_pin_enable, 1'b0);
    chk1(debug_wire_in, 1'b0);
    chk1(pin_oe[3] & pin_out[3], 1'b1);
    chk1(port_data_in[3], 1'b0);
    comp_out_enable = 1'b1;
    #1;
    chk1(pin_out[3], 1'b0);
    ext_en = 6'h04;
    ext_level = 6'h00;
    @(negedge clk);
    opt_write(1'b1, 1'b0);
    chk1(reset_pin_enable, 1'b1);
    chk1(pin_pullup[2], 1'b1);
    chk1(external_reset_n, 1'b0);
    @(negedge clk);
    opt_write(1'b0, 1'b0);
    chk1(reset_pin_enable, 1'b1);
    programming_voltage = 1'b1;
    #1;
    chk1(pin_pullup[2] | pin_pulldown[2], 1'b0);
    programming_voltage = 1'b0;
    $display("option test done");
    por(1'b0);
    chk1(boot_background, 1'b0);
    chk1(reset_pin_enable, 1'b0);
    chk1(debug_pin_enable, 1'b1);
    $display("second reset test done");
    results;
  end
endmodule
